/* File: include/scp_consts.svh */
// Constants of the serial command port: argument codes, counts and sizes.
`ifndef SCP_CONSTS_SVH
`define SCP_CONSTS_SVH

// Fixed argument carried by both buffer instructions
`define SCP_ARG_BUFFER 5'h1a
// Fixed argument carried by the soft reset instruction
`define SCP_ARG_SRESET 5'h1f
// Bit count value of the last bit of a byte
`define SCP_BIT_LAST 3'h7
// Value driven in place of data during the filler byte
`define SCP_FILL_BYTE 8'h00
// Width and depth of the buffer write queue
`define SCP_FIFO_WIDTH 8
`define SCP_FIFO_DEPTH 16
// Level of the select line while idle, also its value out of reset
`define SCP_CS_IDLE 1'b1

`endif

/* File: include/scp_pkg.sv */
// Types shared by the serial command port and its checker.
package scp_pkg;

    // Instruction opcodes, upper three bits of the first byte
    typedef enum logic [2:0] {
        read_reg_cmd     = 3'h0,
        read_buffer_cmd  = 3'h1,
        write_reg_cmd    = 3'h2,
        write_buffer_cmd = 3'h3,
        bit_set_cmd      = 3'h4,
        bit_clear_cmd    = 3'h5,
        scp_unused_cmd   = 3'h6,
        soft_reset_cmd   = 3'h7
    } scp_cmd_e;

    // Frame sequencer, one-hot
    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_head = 3'b010,
        st_body = 3'b100
    } scp_state_e;

endpackage

/* File: src/scp_fifo.sv */
// Flop-based queue with valid/ready on both sides and registered flags.
`timescale 1ns/1ps
module scp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             resetn,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr_idx;
        logic [AW-1:0]               rd_idx;
        logic [CW-1:0]               cnt;
        logic                        full;
        logic                        vld;
        logic [WIDTH-1:0]            dout;
    } scp_fifo_st_s;

    scp_fifo_st_s r_r;
    scp_fifo_st_s r_nxt;
    logic         push;
    logic         pop;

    // Flags and head word are recomputed from next state so ports stay registered
    always_comb begin
        r_nxt = r_r;
        push  = in_valid && !r_r.full;
        pop   = r_r.vld && out_ready;
        if (push) begin
            r_nxt.mem[r_r.wr_idx] = in_data;
            r_nxt.wr_idx          = AW'(r_r.wr_idx + 1'b1);
        end
        if (pop) begin
            r_nxt.rd_idx = AW'(r_r.rd_idx + 1'b1);
        end
        r_nxt.cnt  = CW'(r_r.cnt + CW'(push) - CW'(pop));
        r_nxt.full = (r_nxt.cnt == FULL_CNT);
        r_nxt.vld  = (r_nxt.cnt != '0);
        r_nxt.dout = r_nxt.mem[r_nxt.rd_idx];
    end

    // State register
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    // A full queue refuses; the writer must hold its word
    assign in_ready  = !r_r.full;
    assign out_valid = r_r.vld;
    assign out_data  = r_r.dout;
endmodule

/* File: src/scp_spi_port.sv */
// Serial command front end: mode 0 shifter, instruction decoder, read framing.
`timescale 1ns/1ps
`include "scp_consts.svh"
module scp_spi_port #(
    parameter int FIFO_WIDTH = `SCP_FIFO_WIDTH,
    parameter int FIFO_DEPTH = `SCP_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             resetn,
    // Serial pins, asynchronous to mclk
    input  wire logic             sck,
    input  wire logic             cs_n,
    input  wire logic             si,
    output logic                  so,
    output logic                  so_oe,
    // Register read path to the core
    output logic                  reg_rd_req,
    output logic [4:0]            reg_addr,
    input  wire logic [7:0]       reg_rd_data,
    input  wire logic             reg_rd_slow,
    // Buffer read path to the core
    output logic                  buf_rd_req,
    input  wire logic [7:0]       buf_rd_data,
    // Register write, set and clear path to the core
    output logic                  wr_req,
    output scp_pkg::scp_cmd_e     wr_op,
    output logic [4:0]            wr_addr,
    output logic [7:0]            wr_data,
    // Buffer write stream to the core
    output logic                  buf_wr_valid,
    input  wire logic             buf_wr_ready,
    output logic [FIFO_WIDTH-1:0] buf_wr_data,
    output logic                  buf_wr_overrun,
    // Soft reset request
    output logic                  soft_reset
);
    import scp_pkg::*;

    typedef struct packed {
        // Synchronisers; stage one feeds stage two only
        logic       sck_s1;
        logic       sck_s2;
        logic       sck_d;
        logic       cs_s1;
        logic       cs_s2;
        logic       cs_d;
        logic       si_s1;
        logic       si_s2;
        // Frame state
        scp_state_e st;
        logic [2:0] bit_cnt;
        logic [7:0] rx_sh;
        scp_cmd_e   op;
        logic [4:0] arg;
        // Read side
        logic       reading;
        logic       fetch_wait;
        logic       first_rsp;
        logic [7:0] tx_next;
        logic [7:0] tx_sh;
        logic       so;
        logic       so_oe;
        // Core side
        logic       reg_rd_req;
        logic [4:0] reg_addr;
        logic       buf_rd_req;
        logic       wr_req;
        scp_cmd_e   wr_op;
        logic [4:0] wr_addr;
        logic [7:0] wr_data;
        logic       soft_reset;
        // Buffer write holding stage
        logic       bw_pend;
        logic [7:0] bw_byte;
        logic       bw_ovr;
    } scp_port_s;

    scp_port_s r_r;
    scp_port_s r_nxt;

    logic                  fifo_in_ready;
    logic                  sck_rise;
    logic                  sck_fall;
    logic                  cs_rise;
    logic                  selected;
    logic [7:0]            byte_in;

    // True for opcodes whose first byte is followed by host data
    function automatic logic carries_data(input scp_cmd_e op);
        carries_data = (op == write_reg_cmd) || (op == write_buffer_cmd) ||
                       (op == bit_set_cmd) || (op == bit_clear_cmd);
    endfunction

    // Edge detection looks only at stage two and its delayed copy
    assign sck_rise = r_r.sck_s2 && !r_r.sck_d;
    assign sck_fall = !r_r.sck_s2 && r_r.sck_d;
    assign cs_rise  = r_r.cs_s2 && !r_r.cs_d;
    assign selected = !r_r.cs_s2;
    assign byte_in  = {r_r.rx_sh[6:0], r_r.si_s2};

    always_comb begin
        r_nxt = r_r;

        // Core strobes are single-cycle pulses
        r_nxt.reg_rd_req = 1'b0;
        r_nxt.buf_rd_req = 1'b0;
        r_nxt.wr_req     = 1'b0;
        r_nxt.soft_reset = 1'b0;

        // Pin synchronisers
        r_nxt.sck_s1 = sck;
        r_nxt.sck_s2 = r_r.sck_s1;
        r_nxt.sck_d  = r_r.sck_s2;
        r_nxt.cs_s1  = cs_n;
        r_nxt.cs_s2  = r_r.cs_s1;
        r_nxt.cs_d   = r_r.cs_s2;
        r_nxt.si_s1  = si;
        r_nxt.si_s2  = r_r.si_s1;

        // A registered core answers one cycle after the strobe, so skip the strobe cycle
        if (r_r.fetch_wait && !r_r.reg_rd_req && !r_r.buf_rd_req) begin
            r_nxt.fetch_wait = 1'b0;
            r_nxt.first_rsp  = 1'b0;
            if (r_r.op == read_buffer_cmd) begin
                r_nxt.tx_next = buf_rd_data;
            end else if (r_r.first_rsp && reg_rd_slow) begin
                r_nxt.tx_next = `SCP_FILL_BYTE;
            end else begin
                r_nxt.tx_next = reg_rd_data;
            end
        end

        // Holding stage drains into the queue whenever it has room
        if (r_r.bw_pend && fifo_in_ready) begin
            r_nxt.bw_pend = 1'b0;
        end

        if (cs_rise || !selected) begin
            // Deselect ends every command and frees the output
            r_nxt.st      = st_idle;
            r_nxt.bit_cnt = 3'h0;
            r_nxt.rx_sh   = 8'h00;
            r_nxt.reading = 1'b0;
            r_nxt.so      = 1'b0;
            r_nxt.so_oe   = 1'b0;
        end else if (r_r.st == st_idle) begin
            // Select went low: the next bits form an opcode byte
            r_nxt.st = st_head;
        end else if (sck_rise) begin
            // Shift in on rising edges
            r_nxt.rx_sh   = byte_in;
            r_nxt.bit_cnt = 3'(r_r.bit_cnt + 3'h1);
            if (r_r.bit_cnt == `SCP_BIT_LAST) begin
                if (r_r.st == st_head) begin
                    // Opcode byte: split and decode
                    r_nxt.op  = scp_cmd_e'(byte_in[7:5]);
                    r_nxt.arg = byte_in[4:0];
                    r_nxt.st  = st_body;
                    case (scp_cmd_e'(byte_in[7:5]))
                        read_reg_cmd: begin
                            // Address is passed as is; bank select lives in the core
                            r_nxt.reg_addr   = byte_in[4:0];
                            r_nxt.reg_rd_req = 1'b1;
                            r_nxt.fetch_wait = 1'b1;
                            r_nxt.first_rsp  = 1'b1;
                            r_nxt.reading    = 1'b1;
                        end
                        read_buffer_cmd: begin
                            if (byte_in[4:0] == `SCP_ARG_BUFFER) begin
                                r_nxt.buf_rd_req = 1'b1;
                                r_nxt.fetch_wait = 1'b1;
                                r_nxt.reading    = 1'b1;
                            end
                        end
                        soft_reset_cmd: begin
                            if (byte_in[4:0] == `SCP_ARG_SRESET) begin
                                r_nxt.soft_reset = 1'b1;
                            end
                        end
                        default: begin
                            // Data-carrying and unused codes wait for body bytes
                        end
                    endcase
                end else begin
                    // Body byte
                    if (r_r.op == read_reg_cmd) begin
                        // Further clocks repeat the same register
                        r_nxt.reg_rd_req = 1'b1;
                        r_nxt.fetch_wait = 1'b1;
                    end else if (r_r.reading) begin
                        r_nxt.buf_rd_req = 1'b1;
                        r_nxt.fetch_wait = 1'b1;
                    end else if (carries_data(r_r.op)) begin
                        if (r_r.op != write_buffer_cmd) begin
                            // Only a complete byte acts; a cut byte is dropped
                            r_nxt.wr_req  = 1'b1;
                            r_nxt.wr_op   = r_r.op;
                            r_nxt.wr_addr = r_r.arg;
                            r_nxt.wr_data = byte_in;
                        end else if (r_r.arg == `SCP_ARG_BUFFER) begin
                            // The host cannot be stalled: a byte with no room is lost
                            if (r_nxt.bw_pend) begin
                                r_nxt.bw_ovr = 1'b1;
                            end else begin
                                r_nxt.bw_pend = 1'b1;
                                r_nxt.bw_byte = byte_in;
                            end
                        end
                    end
                end
            end
        end else if (sck_fall && r_r.reading) begin
            // Shift out on falling edges, so the host samples on the next rise
            if (r_r.bit_cnt == 3'h0) begin
                r_nxt.tx_sh = r_r.tx_next;
                r_nxt.so    = r_r.tx_next[7];
                r_nxt.so_oe = 1'b1;
            end else begin
                r_nxt.tx_sh = {r_r.tx_sh[6:0], 1'b0};
                r_nxt.so    = r_r.tx_sh[6];
            end
        end
    end

    // Single state register; select lines reset to idle level
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            r_r       <= '0;
            r_r.st    <= st_idle;
            r_r.op    <= read_reg_cmd;
            r_r.wr_op <= read_reg_cmd;
            r_r.cs_s1 <= `SCP_CS_IDLE;
            r_r.cs_s2 <= `SCP_CS_IDLE;
            r_r.cs_d  <= `SCP_CS_IDLE;
        end else begin
            r_r <= r_nxt;
        end
    end

    // Buffer write queue between the shifter and the core
    scp_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_bw_fifo (
        .mclk      (mclk),
        .resetn    (resetn),
        .in_valid  (r_r.bw_pend),
        .in_ready  (fifo_in_ready),
        .in_data   (FIFO_WIDTH'(r_r.bw_byte)),
        .out_valid (buf_wr_valid),
        .out_ready (buf_wr_ready),
        .out_data  (buf_wr_data)
    );

    // Outputs come straight from state flops
    assign so             = r_r.so;
    assign so_oe          = r_r.so_oe;
    assign reg_rd_req     = r_r.reg_rd_req;
    assign reg_addr       = r_r.reg_addr;
    assign buf_rd_req     = r_r.buf_rd_req;
    assign wr_req         = r_r.wr_req;
    assign wr_op          = r_r.wr_op;
    assign wr_addr        = r_r.wr_addr;
    assign wr_data        = r_r.wr_data;
    assign buf_wr_overrun = r_r.bw_ovr;
    assign soft_reset     = r_r.soft_reset;
endmodule

/* File: verif/scp_checker.sv */
// Port-level assertions for the serial command port.
`timescale 1ns/1ps
module scp_checker #(
    parameter int FIFO_WIDTH = 8
) (
    // Clock and reset
    input wire logic                  mclk,
    input wire logic                  resetn,
    // Serial pins
    input wire logic                  sck,
    input wire logic                  cs_n,
    input wire logic                  so,
    input wire logic                  so_oe,
    // Core side strobes and stream
    input wire logic                  reg_rd_req,
    input wire logic                  buf_rd_req,
    input wire logic                  wr_req,
    input wire scp_pkg::scp_cmd_e     wr_op,
    input wire logic                  soft_reset,
    input wire logic                  buf_wr_valid,
    input wire logic                  buf_wr_ready,
    input wire logic [FIFO_WIDTH-1:0] buf_wr_data
);
    import scp_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);

    // Undriven output must sit low so a floating read is never mistaken for data
    AST_SO_QUIET: assert property (!so_oe |-> !so)
        else $error("so high while not driven");
    AST_OE_RELEASE: assert property ($rose(cs_n) |-> ##[1:6] !so_oe)
        else $error("so_oe kept after select rose");
    AST_OE_FRAMED: assert property (cs_n && $past(cs_n, 6) |-> !so_oe)
        else $error("so_oe high outside a frame");
    // Sync delay puts the pin fall three cycles before the change
    AST_SO_ON_FALL: assert property (so_oe && $past(so_oe) && $changed(so) |-> !$past(sck, 2))
        else $error("so changed away from a falling sck");
    AST_STROBE_ON_RISE: assert property ((reg_rd_req || buf_rd_req || wr_req || soft_reset)
        |-> $past(sck, 2) && $past(sck, 3) && !$past(cs_n, 2))
        else $error("strobe not tied to a rising sck");
    AST_RD_PULSE: assert property (reg_rd_req |=> !reg_rd_req [*8])
        else $error("register fetch longer than one cycle");
    AST_SRST_PULSE: assert property ($rose(soft_reset) |=> $fell(soft_reset))
        else $error("soft reset not a single pulse");
    AST_WR_KIND: assert property (wr_req |-> wr_op inside {write_reg_cmd, bit_set_cmd,
        bit_clear_cmd})
        else $error("write strobe with a bad opcode");
    AST_HEAD_HELD: assert property (buf_wr_valid && !buf_wr_ready
        |=> buf_wr_valid && $stable(buf_wr_data))
        else $error("queue head lost while stalled");
endmodule

bind scp_spi_port scp_checker #(.FIFO_WIDTH(FIFO_WIDTH)) scp_checker_i (
    .mclk(mclk), .resetn(resetn), .sck(sck), .cs_n(cs_n), .so(so), .so_oe(so_oe),
    .reg_rd_req(reg_rd_req), .buf_rd_req(buf_rd_req), .wr_req(wr_req), .wr_op(wr_op),
    .soft_reset(soft_reset), .buf_wr_valid(buf_wr_valid), .buf_wr_ready(buf_wr_ready),
    .buf_wr_data(buf_wr_data)
);

/* File: verif/scp_host.sv */
// Host model: mode 0 serial master with a 32 ns clock.
`timescale 1ns/1ps
module scp_host (
    // Serial pins
    output logic      sck,
    output logic      cs_n,
    output logic      si,
    input  wire logic so,
    // Phase reference; pins change just after its rising edge
    input  wire logic mclk
);
    // Idle: clock low, deselected
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end

    // Select well ahead of the first clock so the header is armed
    task automatic open_f();
        @(posedge mclk);
        cs_n <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask

    // MSB first; fewer than 8 bits leaves a partial byte
    task automatic xbyte(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nbits; i--) begin
            si <= tx[i];
            repeat (3) @(posedge mclk);
            // Take so just before the rise, as a mode 0 master does
            @(negedge mclk);
            rx = {rx[6:0], so};
            @(posedge mclk);
            sck <= 1'b1;
            repeat (4) @(posedge mclk);
            sck <= 1'b0;
        end
    endtask

    // Deselect ends the operation; released data line is flipped
    task automatic close_f();
        repeat (4) @(posedge mclk);
        cs_n <= 1'b1;
        si   <= ~si;
        repeat (8) @(posedge mclk);
        // Return between edges so the bench can read and clear its counters race-free
        @(negedge mclk);
    endtask
endmodule

/* File: verif/scp_spi_port_bench.sv */
// Bench for the serial command port: host model, core stand-in, scenarios.
`timescale 1ns/1ps
module scp_spi_port_bench;
    import scp_pkg::*;
    logic       mclk, resetn, sck, cs_n, si, so, so_oe, slow_sel, so_pin;
    logic       reg_rd_req, reg_rd_slow, buf_rd_req, wr_req, buf_wr_valid;
    logic       buf_wr_ready, buf_wr_overrun, soft_reset;
    logic [4:0] reg_addr, wr_addr;
    logic [7:0] reg_rd_data, buf_rd_data, wr_data, buf_wr_data, rx;
    scp_cmd_e   wr_op;
    int         fail_count, compares, wr_seen, sr_seen, br_seen, oe_seen;

    scp_spi_port scp_spi_port_i (.mclk(mclk), .resetn(resetn), .sck(sck), .cs_n(cs_n),
        .si(si), .so(so), .so_oe(so_oe), .reg_rd_req(reg_rd_req), .reg_addr(reg_addr),
        .reg_rd_data(reg_rd_data), .reg_rd_slow(reg_rd_slow), .buf_rd_req(buf_rd_req),
        .buf_rd_data(buf_rd_data), .wr_req(wr_req), .wr_op(wr_op), .wr_addr(wr_addr),
        .wr_data(wr_data), .buf_wr_valid(buf_wr_valid), .buf_wr_ready(buf_wr_ready),
        .buf_wr_data(buf_wr_data), .buf_wr_overrun(buf_wr_overrun), .soft_reset(soft_reset));
    // Released line shows the opposite level, so a read outside the drive window is caught
    assign so_pin = so_oe ? so : ~so;
    scp_host host_i (.sck(sck), .cs_n(cs_n), .si(si), .so(so_pin), .mclk(mclk));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // Core stand-in answers the cycle after a fetch and counts strobes
    always @(posedge mclk) begin
        reg_rd_data <= {3'h5, reg_addr};
        reg_rd_slow <= slow_sel;
        wr_seen <= wr_seen + int'(wr_req);
        sr_seen <= sr_seen + int'(soft_reset);
        br_seen <= br_seen + int'(buf_rd_req);
        oe_seen <= oe_seen + int'(so_oe);
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic t_reg_read(input logic slow, input logic [4:0] a);
        logic [7:0] r0, r1;
        slow_sel = slow;
        host_i.open_f();
        host_i.xbyte({read_reg_cmd, a}, 8, rx);
        host_i.xbyte(8'h00, 8, r0);
        host_i.xbyte(8'h00, 8, r1);
        host_i.close_f();
        chk(r0, slow ? 8'h00 : {3'h5, a}, "first byte");
        chk(r1, {3'h5, a}, "second byte");
        chk({7'h0, so_oe}, 8'h00, "release");
        $display("test register read done");
    endtask

    // Each frame ends in a partial byte, so the next one must start fresh
    task automatic t_writes();
        scp_cmd_e ops [3] = '{write_reg_cmd, bit_set_cmd, bit_clear_cmd};
        foreach (ops[k]) begin
            wr_seen = 0;
            host_i.open_f();
            host_i.xbyte({ops[k], 5'h11 ^ 5'(k)}, 8, rx);
            host_i.xbyte(8'h96 ^ 8'(k), 8, rx);
            host_i.xbyte(8'h5a, 3, rx);
            host_i.close_f();
            chk(8'(wr_seen), 8'h01, "write strobes");
            chk({5'h0, wr_op}, {5'h0, ops[k]}, "write op");
            chk({3'h0, wr_addr}, {3'h0, 5'h11 ^ 5'(k)}, "write address");
            chk(wr_data, 8'h96 ^ 8'(k), "write data");
        end
        $display("test writes done");
    endtask

    // Unused opcode, bad arguments, then the valid buffer read and soft reset
    task automatic t_misc();
        logic [7:0] hdr [5] = '{8'hc5, 8'h39, 8'hfe, 8'h3a, 8'hff};
        foreach (hdr[k]) begin
            {wr_seen, sr_seen, br_seen, oe_seen} = '0;
            host_i.open_f();
            host_i.xbyte(hdr[k], 8, rx);
            host_i.xbyte(8'h00, (hdr[k] == 8'h3a) ? 8 : 0, rx);
            host_i.close_f();
            chk(8'(sr_seen), {7'h0, hdr[k] == 8'hff}, "soft reset");
            chk({7'h0, br_seen != 0}, {7'h0, hdr[k] == 8'h3a}, "buffer fetch");
            chk({7'h0, oe_seen != 0}, {7'h0, hdr[k] == 8'h3a}, "output drive");
            chk(rx, (hdr[k] == 8'h3a) ? 8'hc3 : 8'h00, "buffer byte");
            chk(8'(wr_seen), 8'h00, "no write");
        end
        $display("test misc commands done");
    endtask

    // Stall the core, overfill the queue, then drain it
    task automatic t_fifo();
        int n;
        n = 0;
        @(posedge mclk) buf_wr_ready <= 1'b0;
        host_i.open_f();
        host_i.xbyte({write_buffer_cmd, 5'h1a}, 8, rx);
        for (int i = 0; i < 18; i++) begin
            host_i.xbyte(8'(i * 7), 8, rx);
        end
        host_i.close_f();
        chk({7'h0, buf_wr_overrun}, 8'h01, "overrun");
        @(posedge mclk) buf_wr_ready <= 1'b1;
        for (int w = 0; w < 80; w++) begin
            @(negedge mclk);
            if (buf_wr_valid === 1'b1) begin
                chk(buf_wr_data, 8'(n * 7), "queue data");
                n++;
            end
        end
        chk(8'(n), 8'h11, "queue count");
        $display("test buffer write done");
    endtask

    task automatic finish_test();
        $display("compares %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        #200000;
        fail_count++;
        finish_test();
    end

    initial begin
        {resetn, slow_sel, reg_rd_data, reg_rd_slow} = '0;
        {fail_count, compares, wr_seen, sr_seen, br_seen, oe_seen} = '0;
        buf_wr_ready = 1'b1;
        buf_rd_data = 8'hc3;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        repeat (4) @(posedge mclk);
        chk({6'h0, so_oe, buf_wr_valid}, 8'h00, "reset outputs");
        t_reg_read(1'b0, 5'h05);
        t_reg_read(1'b0, 5'h1f);
        t_reg_read(1'b1, 5'h1a);
        t_writes();
        t_misc();
        t_fifo();
        finish_test();
    end
endmodule
